/* verilog/lcdt_timing_gen.v */
// Video timing generator driving an 800x480 24-bit RGB panel
// Function
// - Pixel sent as 24-bit word, eight bits each red, green, blue buses.
// - Line is 1056 clocks: 800 valid, 256 blanking.
// - Frame is 525 lines: 480 valid, 45 blanking.
// - Line sync active for 30 clocks at line start.
// - Horizontal back porch of 16 clocks before first valid pixel.
// - Line sync plus back porch fixed at 46 clocks.
// - Horizontal front porch of 210 clocks after valid pixels.
// - Frame sync active for 13 lines at frame start.
// - Vertical back porch 10 lines; sync plus back porch is 23 lines.
// - Vertical front porch of 22 lines after valid lines.
// - Drive scheme-select: data-valid strobe or sync pulses place pixels.
// - Drive static horizontal and vertical scan-direction levels.
`timescale 1ns/1ps
`default_nettype none
`include "lcdt_defs.vh"
module lcdt_timing_gen #(
  parameter [3:0] PCLK_HALF = `LCDT_PCLK_HALF
) (
  input  wire                      mclk,
  input  wire                      rst_n,
  input  wire                      schemeSyncIn,
  input  wire                      hScanDirIn,
  input  wire                      vScanDirIn,
  input  wire [`LCDT_COLOR_W-1:0]  srcRed,
  input  wire [`LCDT_COLOR_W-1:0]  srcGreen,
  input  wire [`LCDT_COLOR_W-1:0]  srcBlue,
  output reg                       pixelReq,
  output reg  [`LCDT_HCNT_W-1:0]   pixelX,
  output reg  [`LCDT_VCNT_W-1:0]   pixelY,
  output wire                      panelPixelClock,
  output reg                       pixelValidStrobe,
  output reg                       lineSync_n,
  output reg                       frameSync_n,
  output reg                       syncSchemeSelect,
  output reg                       horizontalScanDir,
  output reg                       verticalScanDir,
  output reg  [`LCDT_COLOR_W-1:0]  panelRed,
  output reg  [`LCDT_COLOR_W-1:0]  panelGreen,
  output reg  [`LCDT_COLOR_W-1:0]  panelBlue
);

  wire                     pixelTick;
  wire [`LCDT_HCNT_W-1:0]  hCount;
  wire [`LCDT_VCNT_W-1:0]  vCount;
  wire                     lineEnd;
  wire                     frameEnd;
  wire                     hActive;
  wire                     vActive;
  wire [`LCDT_HCNT_W-1:0]  hFirst;
  wire [`LCDT_VCNT_W-1:0]  vFirst;
  reg                      schemeMeta_reg;
  reg                      schemeSync_reg;
  reg                      hDirMeta_reg;
  reg                      hDirSync_reg;
  reg                      vDirMeta_reg;
  reg                      vDirSync_reg;

  // ----------------------------------------------------------------
  // Pixel clock
  // ----------------------------------------------------------------
  lcdt_pclk_div #(
    .HALF_PERIOD (PCLK_HALF)
  ) u_div (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .pclkOut   (panelPixelClock),
    .pixelTick (pixelTick)
  );

  // ----------------------------------------------------------------
  // Position counters
  // ----------------------------------------------------------------
  lcdt_scan_cnt #(
    .WIDTH (`LCDT_HCNT_W),
    .TOTAL (`LCDT_H_TOTAL)
  ) u_hcnt (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .step     (pixelTick),
    .count    (hCount),
    .lastStep (lineEnd)
  );

  lcdt_scan_cnt #(
    .WIDTH (`LCDT_VCNT_W),
    .TOTAL (`LCDT_V_TOTAL)
  ) u_vcnt (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .step     (lineEnd),
    .count    (vCount),
    .lastStep (frameEnd)
  );

  // ----------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------
  // Active window starts right after sync plus back porch; front porch
  // takes the rest, so 30+16+800+210 = 1056 and 13+10+480+22 = 525.
  assign hFirst  = `LCDT_H_SYNC + `LCDT_H_BACK;
  assign vFirst  = `LCDT_V_SYNC + `LCDT_V_BACK;
  assign hActive = (hCount >= hFirst) && (hCount < hFirst + `LCDT_H_ACTIVE);
  assign vActive = (vCount >= vFirst) && (vCount < vFirst + `LCDT_V_ACTIVE);

  // ----------------------------------------------------------------
  // Static strap inputs, synchronised
  // ----------------------------------------------------------------
  // Straps may come from switches, hence two flops each.
  always @(posedge mclk) begin
    if (!rst_n) begin
      schemeMeta_reg <= 1'b0;
      schemeSync_reg <= 1'b0;
      hDirMeta_reg   <= 1'b0;
      hDirSync_reg   <= 1'b0;
      vDirMeta_reg   <= 1'b0;
      vDirSync_reg   <= 1'b0;
    end else begin
      schemeMeta_reg <= schemeSyncIn;
      schemeSync_reg <= schemeMeta_reg;
      hDirMeta_reg   <= hScanDirIn;
      hDirSync_reg   <= hDirMeta_reg;
      vDirMeta_reg   <= vScanDirIn;
      vDirSync_reg   <= vDirMeta_reg;
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      syncSchemeSelect  <= 1'b0;
      horizontalScanDir <= 1'b0;
      verticalScanDir   <= 1'b0;
    end else if (lineEnd && !vActive) begin
      // Only change at the end of a blanking line, so the visible
      // part of a frame never sees two settings
      syncSchemeSelect  <= schemeSync_reg;
      horizontalScanDir <= hDirSync_reg;
      verticalScanDir   <= vDirSync_reg;
    end
  end

  // ----------------------------------------------------------------
  // Panel outputs
  // ----------------------------------------------------------------
  // Registered one mclk after the counters; outputs change with the
  // falling pixel clock edge, a half period before the panel samples.
  always @(posedge mclk) begin
    if (!rst_n) begin
      pixelValidStrobe <= 1'b0;
      lineSync_n       <= 1'b1;
      frameSync_n      <= 1'b1;
      panelRed         <= 8'h00;
      panelGreen       <= 8'h00;
      panelBlue        <= 8'h00;
    end else begin
      pixelValidStrobe <= hActive && vActive;
      lineSync_n       <= ~(hCount < `LCDT_H_SYNC);
      frameSync_n      <= ~(vCount < `LCDT_V_SYNC);
      if (hActive && vActive) begin
        panelRed   <= srcRed;
        panelGreen <= srcGreen;
        panelBlue  <= srcBlue;
      end else begin
        panelRed   <= 8'h00;
        panelGreen <= 8'h00;
        panelBlue  <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pixel source request
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (!rst_n) begin
      pixelReq <= 1'b0;
      pixelX   <= 11'h000;
      pixelY   <= 10'h000;
    end else begin
      pixelReq <= hActive && vActive && pixelTick;
      pixelX   <= hActive ? hCount - hFirst : 11'h000;
      pixelY   <= vActive ? vCount - vFirst : 10'h000;
    end
  end

endmodule // lcdt_timing_gen
`default_nettype wire

/* verilog/lcdt_defs.vh */
// Timing constants for the 800x480 panel timing generator
`ifndef LCDT_DEFS_VH
`define LCDT_DEFS_VH

// ----------------------------------------------------------------
// Horizontal timing, in pixel clocks
// ----------------------------------------------------------------
`define LCDT_H_TOTAL      11'd1056
`define LCDT_H_ACTIVE     11'd800
`define LCDT_H_BLANK      11'd256
`define LCDT_H_SYNC       11'd30
`define LCDT_H_BACK       11'd16
`define LCDT_H_SYNC_BACK  11'd46
`define LCDT_H_FRONT      11'd210

// ----------------------------------------------------------------
// Vertical timing, in lines
// ----------------------------------------------------------------
`define LCDT_V_TOTAL      10'd525
`define LCDT_V_ACTIVE     10'd480
`define LCDT_V_BLANK      10'd45
`define LCDT_V_SYNC       10'd13
`define LCDT_V_BACK       10'd10
`define LCDT_V_SYNC_BACK  10'd23
`define LCDT_V_FRONT      10'd22

// ----------------------------------------------------------------
// Pixel clock divider and widths
// ----------------------------------------------------------------
`define LCDT_PCLK_HALF    4'd1
`define LCDT_COLOR_W      8
`define LCDT_HCNT_W       11
`define LCDT_VCNT_W       10

`endif

/* verilog/lcdt_pclk_div.v */
// Pixel clock divider: makes the panel clock and a tick on its falling edge
`timescale 1ns/1ps
`default_nettype none
module lcdt_pclk_div #(
  parameter [3:0] HALF_PERIOD = 4'd1
) (
  input  wire       mclk,
  input  wire       rst_n,
  output reg        pclkOut,
  output reg        pixelTick
);

  reg [3:0] divCnt_reg;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Tick marks the falling edge so data changes half a period before
  // the panel samples on the rising edge.
  // Clock rests high in reset: its first fall then meets the first
  // output update, so no data change ever lands on a rising edge.
  always @(posedge mclk) begin
    if (!rst_n) begin
      divCnt_reg <= 4'h0;
      pclkOut    <= 1'b1;
      pixelTick  <= 1'b0;
    end else if (divCnt_reg == HALF_PERIOD - 4'h1) begin
      divCnt_reg <= 4'h0;
      pclkOut    <= ~pclkOut;
      pixelTick  <= pclkOut;
    end else begin
      divCnt_reg <= divCnt_reg + 4'h1;
      pixelTick  <= 1'b0;
    end
  end

endmodule // lcdt_pclk_div
`default_nettype wire

/* verilog/lcdt_scan_cnt.v */
// Wrapping counter used for pixel and line positions
`timescale 1ns/1ps
`default_nettype none
module lcdt_scan_cnt #(
  parameter WIDTH = 11,
  parameter [WIDTH-1:0] TOTAL = 11'd1056
) (
  input  wire             mclk,
  input  wire             rst_n,
  input  wire             step,
  output reg  [WIDTH-1:0] count,
  output wire             lastStep
);

  assign lastStep = step && (count == TOTAL - 1'b1);

  always @(posedge mclk) begin
    if (!rst_n) begin
      count <= {WIDTH{1'b0}};
    end else if (lastStep) begin
      count <= {WIDTH{1'b0}};
    end else if (step) begin
      count <= count + 1'b1;
    end
  end

endmodule // lcdt_scan_cnt
`default_nettype wire

/* testbench/lcdt_timing_gen_assertions.sv */
// Timing checker bound to the panel timing generator
`timescale 1ns/1ps
`default_nettype none
module lcdt_timing_gen_assertions #(
  parameter [3:0] PCLK_HALF = 4'h1
) (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       panelPixelClock,
  input wire logic       pixelValidStrobe,
  input wire logic       lineSync_n,
  input wire logic       frameSync_n,
  input wire logic [7:0] panelRed,
  input wire logic [7:0] panelGreen,
  input wire logic [7:0] panelBlue
);
  localparam int HP = PCLK_HALF;
  localparam int PX = 2 * HP;
  localparam int SWM = 30 * PX - 1;
  int   lineClk_reg;
  int   vsLines_reg;
  logic seen_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Clocks since the last line start, and line starts in frame sync
  // ----------------------------------------
  always @(posedge mclk) begin
    if (!rst_n) begin
      lineClk_reg <= 0;
      vsLines_reg <= 0;
      seen_reg    <= 1'b0;
    end else if ($fell(lineSync_n)) begin
      lineClk_reg <= 0;
      vsLines_reg <= frameSync_n ? 0 : vsLines_reg + 1;
      seen_reg    <= 1'b1;
    end else begin
      lineClk_reg <= lineClk_reg + 1;
    end
  end
  sequence s_line_start;
    $fell(lineSync_n);
  endsequence
  sequence s_sync_hold;
    (!lineSync_n throughout ##[SWM:SWM] 1'b1) ##1 lineSync_n;
  endsequence
  a_pclk_half: assert property ($changed(panelPixelClock) |-> ##[HP:HP] $changed(panelPixelClock))
    else $error("pixel clock half period wrong");
  a_out_on_fall: assert property ($changed({lineSync_n, pixelValidStrobe}) |-> $fell(panelPixelClock))
    else $error("output moved off clock fall");
  a_hsync_width: assert property (s_line_start |-> s_sync_hold)
    else $error("line sync width wrong");
  a_line_period: assert property ($fell(lineSync_n) && seen_reg |-> lineClk_reg == 1056 * PX - 1)
    else $error("line period wrong");
  a_valid_start: assert property ($rose(pixelValidStrobe) |-> lineClk_reg == 46 * PX - 1)
    else $error("valid start offset wrong");
  a_valid_end: assert property ($fell(pixelValidStrobe) |-> lineClk_reg == 846 * PX - 1)
    else $error("valid end offset wrong");
  a_sync_blank: assert property (!(lineSync_n && frameSync_n) |-> !pixelValidStrobe)
    else $error("strobe during sync");
  a_colour_blank: assert property (!pixelValidStrobe |-> {panelRed, panelGreen, panelBlue} == 24'h0)
    else $error("colour outside valid area");
  a_vsync_lines: assert property ($rose(frameSync_n) |-> vsLines_reg == 13)
    else $error("frame sync width wrong");
  a_vsync_align: assert property ($changed(frameSync_n) |-> s_line_start)
    else $error("frame sync off line start");
endmodule // lcdt_timing_gen_assertions
bind lcdt_timing_gen lcdt_timing_gen_assertions #(.PCLK_HALF(PCLK_HALF)) lcdt_timing_gen_assertions_inst (
  .mclk(mclk), .rst_n(rst_n), .panelPixelClock(panelPixelClock), .pixelValidStrobe(pixelValidStrobe),
  .lineSync_n(lineSync_n), .frameSync_n(frameSync_n),
  .panelRed(panelRed), .panelGreen(panelGreen), .panelBlue(panelBlue));
`default_nettype wire

/* testbench/lcdt_panel_model.sv */
// Behavioural panel: per-line sync, strobe and pixel figures
`timescale 1ns/1ps
`default_nettype none
module lcdt_panel_model (
  input  wire logic        pclk,
  input  wire logic        lineSync_n,
  input  wire logic        frameSync_n,
  input  wire logic        validStrobe,
  input  wire logic [23:0] rgb,
  output int               lineNo,
  output int               hPer,
  output int               hsW,
  output int               deOff,
  output int               deW,
  output int               vsW,
  output int               zeroBad,
  output logic      [23:0] pix
);
  int   c;
  int   hsC;
  int   deO;
  int   deC;
  logic hsPrev = 1'b1;
  // Panel samples on the rising clock edge
  always @(posedge pclk) begin
    // An unknown level before reset counts as idle high
    hsPrev <= (lineSync_n !== 1'b0);
    if (hsPrev && !lineSync_n) begin
      lineNo <= lineNo + 1;
      hPer   <= c;
      hsW    <= hsC;
      deOff  <= deO;
      deW    <= deC;
      c      <= 1;
      hsC    <= 1;
      deC    <= 0;
      vsW    <= frameSync_n ? vsW : vsW + 1;
    end else begin
      c   <= c + 1;
      hsC <= hsC + int'(!lineSync_n);
      deC <= deC + int'(validStrobe);
      if (validStrobe && deC == 0) deO <= c;
    end
    if (validStrobe) pix <= rgb;
    else if (rgb != 24'h0) zeroBad <= zeroBad + 1;
  end
endmodule // lcdt_panel_model
`default_nettype wire

/* testbench/tb_lcdt_timing_gen.sv */
// Self-checking bench for the panel timing generator
`timescale 1ns/1ps
`default_nettype none
module tb_lcdt_timing_gen;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  straps = 3'h5;
  logic [23:0] srcRgb = 24'ha53cc3;
  wire         pixClk, validStrobe, lineSync_n, frameSync_n, schemeSel, hDir, vDir, pixReq;
  wire  [10:0] pixX;
  wire  [9:0]  pixY;
  wire  [7:0]  red, green, blue;
  wire  [23:0] pix;
  int          lineNo, hPer, hsW, deOff, deW, vsW, zeroBad;
  int          n_fail = 0;
  int          check_count = 0;
  int          cyc = 0;
  lcdt_timing_gen lcdt_timing_gen_inst (.mclk(mclk), .rst_n(rst_n), .schemeSyncIn(straps[2]),
    .hScanDirIn(straps[1]), .vScanDirIn(straps[0]), .srcRed(srcRgb[23:16]), .srcGreen(srcRgb[15:8]),
    .srcBlue(srcRgb[7:0]), .pixelReq(pixReq), .pixelX(pixX), .pixelY(pixY), .panelPixelClock(pixClk),
    .pixelValidStrobe(validStrobe),
    .lineSync_n(lineSync_n), .frameSync_n(frameSync_n), .syncSchemeSelect(schemeSel),
    .horizontalScanDir(hDir), .verticalScanDir(vDir), .panelRed(red), .panelGreen(green), .panelBlue(blue));
  lcdt_panel_model lcdt_panel_model_inst (.pclk(pixClk), .lineSync_n(lineSync_n), .frameSync_n(frameSync_n),
    .validStrobe(validStrobe), .rgb({red, green, blue}), .lineNo(lineNo), .hPer(hPer), .hsW(hsW),
    .deOff(deOff), .deW(deW), .vsW(vsW), .zeroBad(zeroBad), .pix(pix));
  initial forever #50 mclk = ~mclk;
  // Whole run is about 26 lines of 2112 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_line(input int n);
    while (lineNo < n) @(negedge mclk);
  endtask
  task automatic t_reset;
    @(posedge mclk) rst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    check({pixClk, lineSync_n, frameSync_n, validStrobe, schemeSel, hDir, vDir, pixX, pixY}, 28'he000000);
    check({pixClk, lineSync_n, frameSync_n, validStrobe, red, green, blue, pixReq}, 29'h1c000000);
    @(posedge mclk) rst_n <= 1'b1;
  endtask
  task automatic t_blank_line;
    wait_line(3);
    check(hPer, 1056);
    check({hsW, deW}, {32'd30, 32'd0});
  endtask
  task automatic t_straps;
    check({schemeSel, hDir, vDir}, 3'h5);
    @(posedge mclk) straps <= 3'h2;
    repeat (20) @(negedge mclk);
    check({schemeSel, hDir, vDir}, 3'h5);
    wait_line(5);
    check({schemeSel, hDir, vDir}, 3'h2);
  endtask
  task automatic t_frame_sync;
    wait_line(15);
    check(vsW, 13);
    wait_line(24);
    check(deW, 0);
  endtask
  task automatic t_valid_line;
    wait_line(25);
    check({deW, deOff}, {32'd800, 32'd46});
    check(hPer - deOff - deW, 210);
    check({pix, zeroBad}, {24'ha53cc3, 32'd0});
  endtask
  task automatic t_pixel_pos;
    int reqs;
    reqs = 0;
    @(posedge mclk) srcRgb <= 24'h5ac33c;
    @(posedge validStrobe);
    @(negedge mclk);
    check({pixX, pixY}, {11'd0, 10'd1});
    repeat (1598) begin
      @(negedge mclk);
      reqs += int'(pixReq);
    end
    check({validStrobe, pixX}, {1'b1, 11'd799});
    repeat (2) begin
      @(negedge mclk);
      reqs += int'(pixReq);
    end
    check({validStrobe, pixX, pix}, {1'b0, 11'd0, 24'h5ac33c});
    check(reqs, 800);
  endtask
  // Straps moved during a visible line must wait for a blanking line
  task automatic t_strap_hold;
    @(posedge mclk) straps <= 3'h5;
    wait_line(26);
    check({schemeSel, hDir, vDir}, 3'h2);
  endtask
  initial begin
    t_reset();
    t_blank_line();
    t_straps();
    t_frame_sync();
    t_valid_line();
    t_pixel_pos();
    t_strap_hold();
    t_reset();
    report_and_stop();
  end
endmodule // tb_lcdt_timing_gen
`default_nettype wire
